// ==== logic/seq_defines.svh ====
`ifndef SEQ_DEFINES_SVH
`define SEQ_DEFINES_SVH
// ======================================================================
// Clocking
`define CLK_HZ 100000000
`define TICK_HZ 32000
`define US_CYCLES (`CLK_HZ / 1000000)
`define TICK_CYCLES (`CLK_HZ / `TICK_HZ)
`define TRIM_MID 13'h0020
// ======================================================================
// Times in microseconds
`define FIRST_COMPUTE_US 16'h0044
`define SECOND_COMPUTE_US 16'h0014
`define MIN_SLEEP_US 16'h00de
`define LED_WIDTH_US 8'h03
// ======================================================================
// Device register offsets
`define REG_MODE 8'h10
`define REG_RATE 8'h12
`define REG_ROUTE 8'h14
`define REG_DELAY0 8'h30
`define REG_PULSE0 8'h31
`define REG_DELAY1 8'h35
`define REG_PULSE1 8'h36
`define REG_SYNC 8'h38
`define REG_TRIM 8'h4b
`define REG_PINS 8'h4f
// Storage indices
`define IDX_MODE 4'h0
`define IDX_RATE 4'h1
`define IDX_ROUTE 4'h2
`define IDX_DELAY0 4'h3
`define IDX_PULSE0 4'h4
`define IDX_DELAY1 4'h5
`define IDX_PULSE1 4'h6
`define IDX_SYNC 4'h7
`define IDX_TRIM 4'h8
`define IDX_PINS 4'h9
`define REG_COUNT 10
// ======================================================================
// Field values
`define MODE_STANDBY 2'h0
`define MODE_PROGRAM 2'h1
`define MODE_NORMAL 2'h2
`define ROUTE_SECOND_PD 4'h4
`define ROUTE_FIRST_PD 4'h5
`define SYNC_SEL_PIN0 2'h1
`define SYNC_SEL_PIN1 2'h2
`define SYNC_KEY 16'h4000
`define PIN0_BUF_BIT 1
`define PIN1_BUF_BIT 5
// ======================================================================
// Host APB map
`define HOST_CMD 8'h00
`define HOST_STATUS 8'h04
`define HOST_RDATA 8'h08
`define HOST_SYNC 8'h0c
`define CMD_READ_BIT 31
`endif

// ==== logic/seq_pkg.sv ====
package seq_pkg;
  typedef enum logic [2:0] {
    st_idle,
    st_sync_wait,
    st_delay,
    st_pulse,
    st_compute,
    st_sleep
  } seq_state_t;
  typedef enum logic [1:0] {
    hs_idle,
    hs_issue,
    hs_wait
  } host_state_t;
endpackage

// ==== logic/slot_link.sv ====
`timescale 1ns/100ps
interface slot_link;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic reg_ack;
  logic general_pin_zero;
  logic general_pin_one;
  modport device (
    input reg_wr, reg_rd, reg_addr, reg_wdata, general_pin_zero, general_pin_one,
    output reg_rdata, reg_ack
  );
  modport host (
    output reg_wr, reg_rd, reg_addr, reg_wdata, general_pin_zero, general_pin_one,
    input reg_rdata, reg_ack
  );
endinterface

// ==== logic/sample_sequencer_device.sv ====
// Operation
// - First slot then second, never overlapping
// - Each slot uses its own settings
// - First slot time: delay plus count times spacing
// - Second slot time: delay plus count times spacing
// - Host keeps spacing above twice window plus 11
// - First slot delay field sets LED start
// - Second slot delay field sets LED start
// - First slot spacing field sets pulse interval
// - Second slot spacing field sets pulse interval
// - First slot compute interval 68 us
// - Second slot compute interval 20 us
// - Unused slot spends no time
// - Sleep at least 222 us between periods
// - Routing field per slot in routing register
// - Value 4 second photodiode, 5 first
// - Rate register and trim set timing
// - 32 kHz tick paces rate and transitions
// - Host keeps rate below timing limit
// - Selected pin rising edge starts period
// - Sync waits one to two ticks
// - Host follows sync enable procedure
// - Sync edges no faster than allowed rate
// - Mode field: standby, program, normal
//
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
`include "seq_defines.svh"
module sample_sequencer_device (
  input wire logic pclk,
  input wire logic presetn,
  slot_link.device link,
  output logic led_drive,
  output logic [1:0] slot_busy,
  output logic chan1_first_pd,
  output logic chan1_second_pd,
  output logic capture_strobe,
  output logic capture_slot,
  output logic sample_start,
  output logic [1:0] op_state
);
  // ======================================================================
  // Register file
  logic [15:0] regs [`REG_COUNT];
  logic [4:0] hit_idx;
  logic reg_hit;
  logic [3:0] reg_idx;
  logic [1:0] mode;

  function automatic logic [4:0] decode(input logic [7:0] a);
    case (a)
      `REG_MODE: decode = {1'b1, `IDX_MODE};
      `REG_RATE: decode = {1'b1, `IDX_RATE};
      `REG_ROUTE: decode = {1'b1, `IDX_ROUTE};
      `REG_DELAY0: decode = {1'b1, `IDX_DELAY0};
      `REG_PULSE0: decode = {1'b1, `IDX_PULSE0};
      `REG_DELAY1: decode = {1'b1, `IDX_DELAY1};
      `REG_PULSE1: decode = {1'b1, `IDX_PULSE1};
      `REG_SYNC: decode = {1'b1, `IDX_SYNC};
      `REG_TRIM: decode = {1'b1, `IDX_TRIM};
      `REG_PINS: decode = {1'b1, `IDX_PINS};
      default: decode = 5'h00;
    endcase
  endfunction

  assign hit_idx = decode(link.reg_addr);
  assign reg_hit = hit_idx[4];
  assign reg_idx = hit_idx[3:0];
  assign mode = regs[`IDX_MODE][1:0];

  // Config may only change in program mode; mode itself is always writable
  // mode gating
  logic wr_ok;
  assign wr_ok = link.reg_wr && reg_hit &&
                 (reg_idx == `IDX_MODE || mode == `MODE_PROGRAM);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `REG_COUNT; i++) begin
        regs[i] <= 16'h0000;
      end
    end else if (wr_ok) begin
      regs[reg_idx] <= link.reg_wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.reg_ack <= 1'b0;
      link.reg_rdata <= 16'h0000;
    end else begin
      link.reg_ack <= link.reg_wr | link.reg_rd;
      link.reg_rdata <= (link.reg_rd && reg_hit) ? regs[reg_idx] : 16'h0000;
    end
  end

  // ======================================================================
  // Per-slot field selection
  // independent settings
  function automatic logic [7:0] slot_delay(input logic s);
    slot_delay = s ? regs[`IDX_DELAY1][7:0] : regs[`IDX_DELAY0][7:0];
  endfunction
  function automatic logic [7:0] slot_count(input logic s);
    slot_count = s ? regs[`IDX_PULSE1][15:8] : regs[`IDX_PULSE0][15:8];
  endfunction
  function automatic logic [7:0] slot_spacing(input logic s);
    slot_spacing = s ? regs[`IDX_PULSE1][7:0] : regs[`IDX_PULSE0][7:0];
  endfunction
  function automatic logic [3:0] slot_route(input logic s);
    slot_route = s ? regs[`IDX_ROUTE][11:8] : regs[`IDX_ROUTE][7:4];
  endfunction

  // ======================================================================
  // Time bases: microsecond tick and trimmed 32 kHz tick
  logic [6:0] us_cnt;
  logic us_tick;
  logic [12:0] tick_cnt;
  logic [12:0] tick_div;
  logic tick;
  logic next_start;
  // 32 kHz tick paces rate and states
  assign tick_div = 13'(`TICK_CYCLES) + {7'h00, regs[`IDX_TRIM][5:0]} - `TRIM_MID;
  assign us_tick = (us_cnt == 7'(`US_CYCLES - 1));
  assign tick = (tick_cnt >= tick_div - 13'h0001);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      us_cnt <= 7'h00;
      tick_cnt <= 13'h0000;
    end else begin
      // Restart on period start so the LED delay is exact, not phase dependent
      us_cnt <= (us_tick || next_start) ? 7'h00 : us_cnt + 7'h01;
      tick_cnt <= tick ? 13'h0000 : tick_cnt + 13'h0001;
    end
  end

  // ======================================================================
  // Trigger sources
  logic [1:0] pin_meta;
  logic [1:0] pin_sync;
  logic [1:0] pin_prev;
  logic [15:0] period_cnt;
  logic [1:0] sync_sel;
  logic ext_mode;
  logic sync_edge;
  logic timer_fire;
  logic normal;
  assign normal = (mode == `MODE_NORMAL);
  assign sync_sel = regs[`IDX_PINS][3:2];
  assign ext_mode = (regs[`IDX_SYNC] == `SYNC_KEY) &&
    ((sync_sel == `SYNC_SEL_PIN0 && regs[`IDX_PINS][`PIN0_BUF_BIT]) ||
     (sync_sel == `SYNC_SEL_PIN1 && regs[`IDX_PINS][`PIN1_BUF_BIT]));
  assign sync_edge = ext_mode && (sync_sel == `SYNC_SEL_PIN0 ?
    (pin_sync[0] & ~pin_prev[0]) : (pin_sync[1] & ~pin_prev[1]));
  // rate register sets period in ticks
  assign timer_fire = normal && !ext_mode && tick && (period_cnt + 16'h0001 >= regs[`IDX_RATE]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 2'b00;
      pin_sync <= 2'b00;
      pin_prev <= 2'b00;
      period_cnt <= 16'h0000;
    end else begin
      pin_meta <= {link.general_pin_one, link.general_pin_zero};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
      if (!normal || timer_fire) begin
        period_cnt <= 16'h0000;
      end else if (tick) begin
        period_cnt <= period_cnt + 16'h0001;
      end
    end
  end

  // ======================================================================
  // Sequencer
  seq_pkg::seq_state_t state, next_state;
  logic slot, next_slot;
  logic [15:0] cnt, next_cnt;
  logic [7:0] pulse_n, next_pulse_n;
  logic tick_seen, next_tick_seen;
  logic next_capture;
  logic used0, used1;
  logic [15:0] compute_us;
  logic cnt_done;
  logic [15:0] cnt_inc;

  // Zero pulse count marks a slot as unused
  assign used0 = (slot_count(1'b0) != 8'h00);
  assign used1 = (slot_count(1'b1) != 8'h00);
  assign compute_us = slot ? `SECOND_COMPUTE_US : `FIRST_COMPUTE_US;
  assign cnt_inc = cnt + 16'h0001;

  always_comb begin
    next_state = state;
    next_slot = slot;
    next_cnt = cnt;
    next_pulse_n = pulse_n;
    next_tick_seen = tick_seen;
    next_capture = 1'b0;
    next_start = 1'b0;
    cnt_done = 1'b0;
    case (state)
      seq_pkg::st_idle: begin
        next_cnt = 16'h0000;
        next_tick_seen = 1'b0;
        if (sync_edge) begin
          next_state = seq_pkg::st_sync_wait;
        end else if (timer_fire) begin
          next_start = 1'b1;
        end
      end
      // start on second tick after edge
      seq_pkg::st_sync_wait: begin
        if (tick) begin
          next_tick_seen = 1'b1;
          next_start = tick_seen;
        end
      end
      seq_pkg::st_delay: begin
        if (us_tick) begin
          next_cnt = cnt_inc;
          if (cnt_inc >= {8'h00, slot_delay(slot)}) begin
            next_state = seq_pkg::st_pulse;
            next_cnt = 16'h0000;
            next_pulse_n = 8'h00;
          end
        end
      end
      seq_pkg::st_pulse: begin
        if (us_tick) begin
          next_cnt = cnt_inc;
          if (cnt_inc >= {8'h00, slot_spacing(slot)}) begin
            next_cnt = 16'h0000;
            next_pulse_n = pulse_n + 8'h01;
            if (pulse_n + 8'h01 == slot_count(slot)) begin
              next_state = seq_pkg::st_compute;
            end
          end
        end
      end
      seq_pkg::st_compute: begin
        if (us_tick) begin
          next_cnt = cnt_inc;
          cnt_done = (cnt_inc >= compute_us);
        end
        // second slot follows, skipped if unused
        if (cnt_done) begin
          next_capture = 1'b1;
          next_cnt = 16'h0000;
          if (!slot && used1) begin
            next_slot = 1'b1;
            next_state = seq_pkg::st_delay;
          end else begin
            next_state = seq_pkg::st_sleep;
          end
        end
      end
      seq_pkg::st_sleep: begin
        if (us_tick) begin
          next_cnt = cnt_inc;
          if (cnt_inc >= `MIN_SLEEP_US) begin
            next_state = seq_pkg::st_idle;
          end
        end
      end
      default: next_state = seq_pkg::st_idle;
    endcase
    if (next_start) begin
      next_cnt = 16'h0000;
      next_slot = !used0;
      next_state = (used0 || used1) ? seq_pkg::st_delay : seq_pkg::st_sleep;
    end
    if (!normal) begin
      next_state = seq_pkg::st_idle;
      next_start = 1'b0;
      next_capture = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= seq_pkg::st_idle;
      slot <= 1'b0;
      cnt <= 16'h0000;
      pulse_n <= 8'h00;
      tick_seen <= 1'b0;
    end else begin
      state <= next_state;
      slot <= next_slot;
      cnt <= next_cnt;
      pulse_n <= next_pulse_n;
      tick_seen <= next_tick_seen;
    end
  end

  // ======================================================================
  // Registered outputs
  logic [3:0] route_now;
  logic slot_on;
  assign slot_on = (next_state == seq_pkg::st_delay || next_state == seq_pkg::st_pulse ||
                    next_state == seq_pkg::st_compute);
  assign route_now = slot_route(next_slot);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_drive <= 1'b0;
      slot_busy <= 2'b00;
      chan1_first_pd <= 1'b0;
      chan1_second_pd <= 1'b0;
      capture_strobe <= 1'b0;
      capture_slot <= 1'b0;
      sample_start <= 1'b0;
      op_state <= `MODE_STANDBY;
    end else begin
      led_drive <= (next_state == seq_pkg::st_pulse) && (next_cnt < {8'h00, `LED_WIDTH_US});
      slot_busy <= slot_on ? (next_slot ? 2'b10 : 2'b01) : 2'b00;
      chan1_first_pd <= slot_on && (route_now == `ROUTE_FIRST_PD);
      chan1_second_pd <= slot_on && (route_now == `ROUTE_SECOND_PD);
      capture_strobe <= next_capture;
      capture_slot <= next_capture ? slot : capture_slot;
      sample_start <= next_start;
      op_state <= mode;
    end
  end
endmodule

// ==== logic/sample_sequencer_host.sv ====
`timescale 1ns/100ps
`include "seq_defines.svh"
module sample_sequencer_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  slot_link.host link
);
  // ======================================================================
  // APB slave, no wait state; every answer comes from a flop
  logic setup;
  logic access;
  logic mapped;
  logic [31:0] rd_mux;
  seq_pkg::host_state_t hstate;
  logic [15:0] rd_data;
  logic [1:0] sync_level;
  logic cmd_take;

  assign setup = psel && !penable && !pready;
  assign access = psel && penable && pready;
  assign mapped = (paddr == `HOST_CMD) || (paddr == `HOST_STATUS) ||
                  (paddr == `HOST_RDATA) || (paddr == `HOST_SYNC);
  assign rd_mux = (paddr == `HOST_STATUS) ? {31'h00000000, hstate != seq_pkg::hs_idle} :
                  (paddr == `HOST_RDATA) ? {16'h0000, rd_data} :
                  (paddr == `HOST_SYNC) ? {30'h00000000, sync_level} : 32'h00000000;
  // Commands while busy are dropped; software polls status first
  assign cmd_take = access && pwrite && (paddr == `HOST_CMD) && (hstate == seq_pkg::hs_idle);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= (setup && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // ======================================================================
  // Sync pin levels driven by software
  // software paces edges and follows the enable order
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_level <= 2'b00;
      link.general_pin_zero <= 1'b0;
      link.general_pin_one <= 1'b0;
    end else begin
      if (access && pwrite && paddr == `HOST_SYNC) begin
        sync_level <= pwdata[1:0];
      end
      link.general_pin_zero <= sync_level[0];
      link.general_pin_one <= sync_level[1];
    end
  end

  // ======================================================================
  // Device register transfer
  // timing values come from software writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hstate <= seq_pkg::hs_idle;
      link.reg_wr <= 1'b0;
      link.reg_rd <= 1'b0;
      link.reg_addr <= 8'h00;
      link.reg_wdata <= 16'h0000;
      rd_data <= 16'h0000;
    end else begin
      link.reg_wr <= 1'b0;
      link.reg_rd <= 1'b0;
      case (hstate)
        seq_pkg::hs_idle: begin
          if (cmd_take) begin
            link.reg_addr <= pwdata[23:16];
            link.reg_wdata <= pwdata[15:0];
            link.reg_rd <= pwdata[`CMD_READ_BIT];
            link.reg_wr <= !pwdata[`CMD_READ_BIT];
            hstate <= seq_pkg::hs_wait;
          end
        end
        seq_pkg::hs_wait: begin
          if (link.reg_ack) begin
            rd_data <= link.reg_rdata;
            hstate <= seq_pkg::hs_idle;
          end
        end
        default: hstate <= seq_pkg::hs_idle;
      endcase
    end
  end
endmodule

// ==== sim/sample_sequencer_properties.sv ====
`timescale 1ns/100ps
module sample_sequencer_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_ack,
  input wire logic led_drive,
  input wire logic [1:0] slot_busy,
  input wire logic chan1_first_pd,
  input wire logic chan1_second_pd,
  input wire logic capture_strobe,
  input wire logic sample_start,
  input wire logic [1:0] op_state
);
  // ========
  // Helpers, gap saturates so the first period is not flagged
  logic [8:0] led_len;
  logic [15:0] gap;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_len <= 9'h000;
      gap <= 16'hffff;
    end else begin
      led_len <= led_drive ? led_len + 9'h001 : 9'h000;
      gap <= capture_strobe ? 16'h0000 : gap + {15'h0000, gap != 16'hffff};
    end
  end
  // ========
  // Properties
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_req;
    reg_wr || reg_rd;
  endsequence
  sequence s_mode_wr;
    reg_wr && reg_addr == 8'h10;
  endsequence
  property p_ack;
    s_req |=> reg_ack;
  endproperty
  property p_ack_cause;
    reg_ack |-> $past(reg_wr || reg_rd);
  endproperty
  property p_mode;
    s_mode_wr |-> ##[1:2] op_state == reg_wdata[1:0];
  endproperty
  property p_exclusive;
    slot_busy != 2'b11;
  endproperty
  property p_led_slot;
    led_drive |-> slot_busy != 2'b00 && op_state == 2'h2;
  endproperty
  property p_led_width;
    $fell(led_drive) |-> led_len == 9'h12c;
  endproperty
  property p_route;
    !(chan1_first_pd && chan1_second_pd);
  endproperty
  property p_route_idle;
    slot_busy == 2'b00 && $past(slot_busy) == 2'b00 |-> !chan1_first_pd && !chan1_second_pd;
  endproperty
  property p_start;
    sample_start |=> !sample_start;
  endproperty
  property p_sleep;
    sample_start |-> gap >= 16'h56ae;
  endproperty
  a_ack: assert property (p_ack) else $error("register ack missing");
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  a_mode: assert property (p_mode) else $error("mode not applied");
  a_exclusive: assert property (p_exclusive) else $error("slots overlap");
  a_led_slot: assert property (p_led_slot) else $error("led outside slot");
  a_led_width: assert property (p_led_width) else $error("led width wrong");
  a_route: assert property (p_route) else $error("both inputs routed");
  a_route_idle: assert property (p_route_idle) else $error("route while idle");
  a_start: assert property (p_start) else $error("start pulse too long");
  a_sleep: assert property (p_sleep) else $error("sleep too short");
endmodule

// ==== sim/dual_slot_sample_sequencer_tb_top.sv ====
`timescale 1ns/100ps
module dual_slot_sample_sequencer_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic led_q = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, led_drive, chan1_first_pd, chan1_second_pd;
  logic capture_strobe, capture_slot, sample_start;
  logic [1:0] slot_busy, op_state;
  logic [1:0] busyq[$];
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;
  int li = 0;
  int ci = 0;
  int tick, t0;
  int starts[$], leds[$], caps[$], cslot[$];
  int mdl[int];
  int d[2], n[2], sp[2];
  int comp[2] = '{68, 20};
  int map[10] = '{'h10, 'h12, 'h14, 'h30, 'h31, 'h35, 'h36, 'h38, 'h4b, 'h4f};
  int cfg_a[9] = '{'h14, 'h30, 'h31, 'h35, 'h36, 'h12, 'h4b, 'h4f, 'h38};
  int cfg_v[9] = '{'h0450, 'h17, 'h0213, 'h1e, 'h0119, 'h1, 'h28, 'h0, 'h0};
  slot_link link ();
  sample_sequencer_host sample_sequencer_host_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(link));
  sample_sequencer_device sample_sequencer_device_i (
    .pclk(pclk), .presetn(presetn), .link(link), .led_drive(led_drive),
    .slot_busy(slot_busy), .chan1_first_pd(chan1_first_pd),
    .chan1_second_pd(chan1_second_pd), .capture_strobe(capture_strobe),
    .capture_slot(capture_slot), .sample_start(sample_start), .op_state(op_state));
  sample_sequencer_properties sample_sequencer_properties_i (
    .pclk(pclk), .presetn(presetn), .reg_wr(link.reg_wr), .reg_rd(link.reg_rd),
    .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata), .reg_ack(link.reg_ack),
    .led_drive(led_drive), .slot_busy(slot_busy), .chan1_first_pd(chan1_first_pd),
    .chan1_second_pd(chan1_second_pd), .capture_strobe(capture_strobe),
    .sample_start(sample_start), .op_state(op_state));
  always #5 pclk = ~pclk;
  // ========
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkr(input int v, input int lo, input int hi);
    compares++;
    if (v < lo || v > hi) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h to %h", $time, v, lo, hi);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_idle();
    rd = 32'h00000001;
    while (rd[0] !== 1'b0) apb(1'b0, 8'h04, 32'h00000000);
  endtask
  task automatic dwr(input logic [7:0] a, input logic [15:0] v);
    apb(1'b1, 8'h00, {8'h00, a, v});
    wait_idle();
    if (mdl.exists(a) && (a == 8'h10 || mdl['h10] % 4 == 1)) mdl[a] = v;
    if (a == 8'h10) chk(op_state, v[1:0]);
  endtask
  task automatic drd(input logic [7:0] a);
    apb(1'b1, 8'h00, {8'h80, a, 16'h0000});
    wait_idle();
    apb(1'b0, 8'h08, 32'h00000000);
    chk({16'h0000, rd[15:0]}, mdl.exists(a) ? mdl[a] : 0);
  endtask
  task automatic chk_period(input int s0);
    int t;
    t = s0;
    d = '{mdl['h30] % 256, mdl['h35] % 256};
    n = '{mdl['h31] / 256, mdl['h36] / 256};
    sp = '{mdl['h31] % 256, mdl['h36] % 256};
    for (int sl = 0; sl < 2; sl++) begin
      for (int p = 0; p < n[sl]; p++) begin
        chkr(leds[li] - t - (d[sl] + p * sp[sl]) * 100, -5, 5);
        chk(busyq[li], sl ? 2'b10 : 2'b01);
        li++;
      end
      if (n[sl] != 0) begin
        t = t + (d[sl] + n[sl] * sp[sl] + comp[sl]) * 100;
        chkr(caps[ci] - t, -5, 5);
        chk(cslot[ci], sl);
        ci++;
      end
    end
    chk(leds.size(), li);
  endtask
  task automatic report_and_stop();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ========
  // Monitor
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    led_q <= led_drive;
    if (sample_start === 1'b1) starts.push_back(cyc);
    if (capture_strobe === 1'b1) begin
      caps.push_back(cyc);
      cslot.push_back(capture_slot);
    end
    if (led_drive === 1'b1 && led_q === 1'b0) begin
      leds.push_back(cyc);
      busyq.push_back(slot_busy);
      chk({chan1_first_pd, chan1_second_pd}, slot_busy[0] ? 2'b10 : 2'b01);
    end
  end
  initial begin
    repeat (99000) @(posedge pclk);
    num_errors++;
    report_and_stop();
  end
  initial begin
    rd = $urandom(32'h8055);
    foreach (map[i]) mdl[map[i]] = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h10, 32'h00000000);
    chk(err, 1'b1);
    chk(rd, 32'h00000000);
    dwr(8'h12, 16'h0005);
    drd(8'h12);
    dwr(8'h10, 16'h0001);
    for (int i = 1; i < 10; i++) begin
      dwr(map[i][7:0], 16'($urandom));
      drd(map[i][7:0]);
    end
    drd(8'h20);
    foreach (cfg_a[i]) dwr(cfg_a[i][7:0], cfg_v[i][15:0]);
    tick = 3125 + mdl['h4b] % 64 - 32;
    // Timer paced period with both slots
    t0 = cyc;
    dwr(8'h10, 16'h0002);
    while (starts.size() < 2) @(posedge pclk);
    dwr(8'h10, 16'h0001);
    chkr(starts[0] - t0, 0, tick + 50);
    chk_period(starts[0]);
    chkr(starts[1] - caps[ci - 1], 22195, 22200 + tick + 10);
    // External sync, first slot unused
    dwr(8'h31, 16'h0013);
    dwr(8'h35, 16'h0017);
    dwr(8'h36, 16'h0113);
    dwr(8'h4f, 16'h0006);
    dwr(8'h38, 16'h4000);
    dwr(8'h10, 16'h0002);
    repeat (tick + 100) @(posedge pclk);
    chk(starts.size(), 2);
    apb(1'b1, 8'h0c, 32'h00000001);
    t0 = cyc;
    while (starts.size() < 3) @(posedge pclk);
    chkr(starts[2] - t0, tick - 10, 2 * tick + 10);
    repeat (500) @(posedge pclk);
    apb(1'b1, 8'h0c, 32'h00000000);
    apb(1'b1, 8'h0c, 32'h00000001);
    while (caps.size() <= ci) @(posedge pclk);
    chk_period(starts[2]);
    repeat (22200 + 2 * tick + 100) @(posedge pclk);
    chk(starts.size(), 3);
    report_and_stop();
  end
endmodule
